// file: udc_cfg.svh
`ifndef UDC_CFG_SVH
`define UDC_CFG_SVH
`define UDC_DW 16
// command codes
`define UDC_CMD_FIFO_WR 4'h0
`define UDC_CMD_FIFO_RD 4'h1
`define UDC_CMD_EP_WR 4'h2
`define UDC_CMD_EP_RD 4'h3
`define UDC_CMD_VALIDATE 4'h6
`define UDC_CMD_CLEAR 4'h7
`define UDC_CMD_ADDR_WR 8'hB6
`define UDC_CMD_ADDR_RD 8'hB7
`define UDC_CMD_MODE_WR 8'hB8
`define UDC_CMD_MODE_RD 8'hB9
`define UDC_CMD_HW_WR 8'hBA
`define UDC_CMD_HW_RD 8'hBB
`define UDC_CMD_MASK_WR 8'hC2
`define UDC_CMD_MASK_RD 8'hC3
`define UDC_CMD_DMA_WR 8'hF0
`define UDC_CMD_DMA_RD 8'hF1
`define UDC_CMD_CNT_WR 8'hF2
`define UDC_CMD_CNT_RD 8'hF3
`define UDC_CMD_RESET 8'hF6
// dma setup fields
`define UDC_DMA_CNT_EN_BIT 2
`define UDC_DMA_RUN_BIT 3
`define UDC_DMA_SHORT_BIT 4
`define UDC_DMA_DIR_BIT 5
`define UDC_DMA_EP_LSB 8
// reset values
`define UDC_RST_WORD 16'h0000
`define UDC_RST_MASK 32'h0000_0000
// host register word indexes (haddr[4:2])
`define UDC_H_CMD 3'h0
`define UDC_H_DATA 3'h1
`define UDC_H_DMA 3'h2
`define UDC_H_STATUS 3'h3
`define UDC_H_CTRL 3'h4
`endif

// file: udc_pkg.sv
package udc_pkg;
  typedef enum logic [1:0] {H_IDLE, H_WR, H_RD} udc_host_e;
  // device end state
  typedef struct packed {
    logic [15:0][15:0] epSetup;
    logic [15:0] devAddr;
    logic [15:0] opMode;
    logic [15:0] hwSetup;
    logic [31:0] irqMask;
    logic [15:0] dmaSetup;
    logic [15:0] dmaCount;
    logic [15:0] dmaCnt;
    logic [7:0] cmd;
    logic wordSel;
    logic lenNext;
    logic [15:0] bufLeft;
    logic shortArmed;
    logic [15:0] rdata;
    logic rdValid;
    logic dmaReq;
    logic fifoWr;
    logic [15:0] fifoWrData;
    logic fifoWrOneByte;
    logic fifoRd;
    logic [3:0] fifoEp;
    logic bufClear;
    logic bufValidate;
    logic dmaDone;
    logic cmdStrobe;
  } udc_dev_s;
  // host end state
  typedef struct packed {
    udc_host_e st;
    logic [2:0] idx;
    logic hready;
    logic [31:0] hrdata;
    logic acc;
    logic wr;
    logic a0;
    logic [15:0] wdata;
    logic dmaAck;
    logic stop;
  } udc_host_s;
endpackage

// file: udc_port_if.sv
`timescale 1ns/1ps
interface udc_port_if;
  logic acc;
  logic wr;
  logic phaseSelectAddrBit;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic rdValid;
  logic dmaReq;
  logic dmaAck;
  logic transferStopInput;
  modport dev (input acc, wr, phaseSelectAddrBit, wdata, dmaAck, transferStopInput,
               output rdata, rdValid, dmaReq);
  modport host (output acc, wr, phaseSelectAddrBit, wdata, dmaAck, transferStopInput,
                input rdata, rdValid, dmaReq);
endinterface // udc_port_if

// file: udc_host_end.sv
`timescale 1ns/1ps
`include "udc_cfg.svh"
module udc_host_end
  import udc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  udc_port_if.host bus,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  udc_host_s q;
  udc_host_s n;

  // ahb slave and port sequencing
  always_comb
  begin
    n = q;
    n.acc = 1'b0;
    n.dmaAck = 1'b0;
    n.stop = 1'b0;
    case (q.st)
      H_IDLE:
      begin
        if (hsel && htrans[1] && q.hready)
        begin
          n.idx = haddr[4:2];
          if (hwrite)
          begin
            n.st = H_WR; // wait one cycle for hwdata
            n.hready = 1'b0;
          end
          else if (haddr[4:2] == `UDC_H_DATA || haddr[4:2] == `UDC_H_DMA)
          begin
            n.acc = (haddr[4:2] == `UDC_H_DATA);
            n.dmaAck = (haddr[4:2] == `UDC_H_DMA);
            n.wr = 1'b0;
            n.a0 = 1'b0;
            n.hready = 1'b0;
            n.st = H_RD;
          end
          else if (haddr[4:2] == `UDC_H_STATUS)
            n.hrdata = {31'h0000_0000, bus.dmaReq};
          else
            n.hrdata = 32'h0000_0000;
        end
      end
      H_WR:
      begin
        n.hready = 1'b1;
        n.st = H_IDLE;
        n.wr = 1'b1;
        case (q.idx)
          `UDC_H_CMD:
          begin
            n.acc = 1'b1;
            n.a0 = 1'b1;
            n.wdata = {8'h00, hwdata[7:0]};
          end
          `UDC_H_DATA:
          begin
            n.acc = 1'b1;
            n.a0 = 1'b0;
            n.wdata = hwdata[15:0];
          end
          `UDC_H_DMA:
          begin
            n.dmaAck = 1'b1;
            n.wdata = hwdata[15:0];
          end
          `UDC_H_CTRL: n.stop = hwdata[0];
          default: n.wr = q.wr;
        endcase
      end
      H_RD:
      begin
        if (bus.rdValid)
        begin
          n.hrdata = {16'h0000, bus.rdata};
          n.hready = 1'b1;
          n.st = H_IDLE;
        end
      end
      default: n.st = H_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '0;
      q.st <= H_IDLE;
      q.hready <= 1'b1;
    end
    else
      q <= n;
  end

  assign hreadyout = q.hready;
  assign hresp = 1'b0;
  assign hrdata = q.hrdata;
  assign bus.acc = q.acc;
  assign bus.wr = q.wr;
  assign bus.phaseSelectAddrBit = q.a0;
  assign bus.wdata = q.wdata;
  assign bus.dmaAck = q.dmaAck;
  assign bus.transferStopInput = q.stop;
endmodule // udc_host_end

// file: udc_dev_end.sv
`timescale 1ns/1ps
`include "udc_cfg.svh"
module udc_dev_end
  import udc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  udc_port_if.dev bus,
  input wire logic [15:0] fifoRdData,
  input wire logic outBufferEmpty,
  input wire logic shortPacketRcvd,
  input wire logic eopDetected,
  input wire logic isoEndpoint,
  output logic fifoWrStrobe,
  output logic [15:0] fifoWrData,
  output logic fifoWrOneByte,
  output logic fifoRdStrobe,
  output logic [3:0] fifoEp,
  output logic bufferClear,
  output logic bufferValidate,
  output logic dmaDone,
  output logic cmdStrobe,
  output logic [7:0] cmdCode,
  output logic [15:0] devAddress
);
  udc_dev_s q;
  udc_dev_s n;
  logic runNow;
  logic dirIn;
  logic cntEn;
  logic shortEn;
  logic [15:0] wd;

  // counter step: two per word, one for a final byte
  function automatic logic [15:0] cntStep(input logic [15:0] c);
    cntStep = (c >= 16'h0002) ? c - 16'h0002 : 16'h0000;
  endfunction

  // readback of registers, one word per access
  function automatic logic [15:0] regRead(input udc_dev_s s, input logic [7:0] c);
    regRead = `UDC_RST_WORD;
    if (c[7:4] == `UDC_CMD_EP_RD)
      regRead = s.epSetup[c[3:0]];
    else
      case (c)
        `UDC_CMD_ADDR_RD: regRead = s.devAddr;
        `UDC_CMD_MODE_RD: regRead = s.opMode;
        `UDC_CMD_HW_RD: regRead = s.hwSetup;
        `UDC_CMD_MASK_RD: regRead = s.wordSel ? s.irqMask[31:16] : s.irqMask[15:0];
        `UDC_CMD_DMA_RD: regRead = s.dmaSetup;
        `UDC_CMD_CNT_RD: regRead = s.dmaCount;
        default: regRead = `UDC_RST_WORD;
      endcase
  endfunction

  assign runNow = q.dmaSetup[`UDC_DMA_RUN_BIT];
  assign dirIn = q.dmaSetup[`UDC_DMA_DIR_BIT];
  assign cntEn = q.dmaSetup[`UDC_DMA_CNT_EN_BIT];
  assign shortEn = q.dmaSetup[`UDC_DMA_SHORT_BIT];
  assign wd = bus.wdata;

  // command decode, data phase and dma end conditions
  always_comb
  begin
    n = q;
    n.rdValid = 1'b0;
    n.fifoWr = 1'b0;
    n.fifoRd = 1'b0;
    n.bufClear = 1'b0;
    n.bufValidate = 1'b0;
    n.dmaDone = 1'b0;
    n.cmdStrobe = 1'b0;
    if (bus.acc && bus.phaseSelectAddrBit)
    begin
      n.cmd = wd[7:0];
      n.wordSel = 1'b0;
      n.lenNext = 1'b1;
      n.cmdStrobe = 1'b1;
      if (wd[7:4] == `UDC_CMD_VALIDATE)
      begin
        n.bufValidate = 1'b1;
        n.fifoEp = wd[3:0];
      end
      if (wd[7:4] == `UDC_CMD_CLEAR)
      begin
        n.bufClear = 1'b1;
        n.fifoEp = wd[3:0];
      end
      if (wd[7:0] == `UDC_CMD_RESET)
      begin
        n.epSetup = '0;
        n.devAddr = `UDC_RST_WORD;
        n.opMode = `UDC_RST_WORD;
        n.hwSetup = `UDC_RST_WORD;
        n.irqMask = `UDC_RST_MASK;
        n.dmaSetup = `UDC_RST_WORD;
        n.dmaCount = `UDC_RST_WORD;
        n.shortArmed = 1'b0;
      end
    end
    else if (bus.acc)
    begin
      // data phase on the last command; read data only moves on a read
      n.rdValid = !bus.wr;
      if (q.cmd == `UDC_CMD_MASK_WR || q.cmd == `UDC_CMD_MASK_RD)
        n.wordSel = !q.wordSel;
      if (bus.wr)
      begin
        if (q.cmd[7:4] == `UDC_CMD_EP_WR)
          n.epSetup[q.cmd[3:0]] = wd;
        case (q.cmd)
          `UDC_CMD_ADDR_WR: n.devAddr = wd;
          `UDC_CMD_MODE_WR: n.opMode = wd;
          `UDC_CMD_HW_WR: n.hwSetup = wd;
          `UDC_CMD_MASK_WR:
          begin
            if (q.wordSel)
              n.irqMask[31:16] = wd;
            else
              n.irqMask[15:0] = wd;
          end
          `UDC_CMD_DMA_WR:
          begin
            n.dmaSetup = wd;
            if (wd[`UDC_DMA_RUN_BIT] && !runNow)
            begin
              n.dmaCnt = q.dmaCount;
              n.shortArmed = 1'b0;
            end
          end
          `UDC_CMD_CNT_WR: n.dmaCount = wd;
          default: n.devAddr = n.devAddr;
        endcase
        if (q.cmd[7:4] == `UDC_CMD_FIFO_WR && q.cmd[3:0] != 4'h0)
        begin
          n.fifoWr = 1'b1;
          n.fifoWrData = wd;
          n.fifoEp = q.cmd[3:0];
          n.lenNext = 1'b0;
          if (q.lenNext)
          begin
            n.bufLeft = wd;
            n.fifoWrOneByte = 1'b0;
          end
          else
          begin
            n.fifoWrOneByte = (q.bufLeft == 16'h0001);
            n.bufLeft = cntStep(q.bufLeft);
          end
        end
      end
      else if (q.cmd[7:4] == `UDC_CMD_FIFO_RD && q.cmd[3:0] != 4'h1)
      begin
        n.rdata = fifoRdData;
        n.fifoRd = 1'b1;
        n.fifoEp = q.cmd[3:0];
      end
      else
        n.rdata = regRead(q, q.cmd);
    end
    // dma word transfer
    if (bus.dmaAck && q.dmaReq)
    begin
      n.fifoEp = q.dmaSetup[`UDC_DMA_EP_LSB +: 4];
      n.dmaCnt = cntStep(q.dmaCnt);
      if (dirIn)
      begin
        n.fifoWr = 1'b1;
        n.fifoWrData = wd;
        n.fifoWrOneByte = cntEn && (q.dmaCnt == 16'h0001);
      end
      else
      begin
        n.fifoRd = 1'b1;
        n.rdata = fifoRdData;
        n.rdValid = 1'b1;
      end
      if (n.dmaCnt == 16'h0000 && (cntEn || (shortEn && dirIn && !isoEndpoint)))
      begin
        n.dmaSetup[`UDC_DMA_RUN_BIT] = 1'b0;
        n.dmaDone = 1'b1;
        n.bufValidate = dirIn;
      end
    end
    // arm short packet end on out endpoints
    if (runNow && shortEn && !dirIn && !isoEndpoint && shortPacketRcvd)
      n.shortArmed = 1'b1;
    if (runNow && q.shortArmed && outBufferEmpty)
    begin
      n.dmaSetup[`UDC_DMA_RUN_BIT] = 1'b0;
      n.shortArmed = 1'b0;
      n.dmaDone = 1'b1;
    end
    if (runNow && isoEndpoint && eopDetected)
    begin
      n.dmaSetup[`UDC_DMA_RUN_BIT] = 1'b0;
      n.dmaDone = 1'b1;
    end
    // external stop input
    if (runNow && bus.transferStopInput)
    begin
      n.dmaSetup[`UDC_DMA_RUN_BIT] = 1'b0;
      n.dmaDone = 1'b1;
      n.fifoEp = q.dmaSetup[`UDC_DMA_EP_LSB +: 4];
      n.bufClear = !dirIn;
      n.bufValidate = dirIn;
    end
    // software clear of the run bit ends dma with no done event
    if (!n.dmaSetup[`UDC_DMA_RUN_BIT])
      n.shortArmed = 1'b0;
    n.dmaReq = n.dmaSetup[`UDC_DMA_RUN_BIT] && (n.dmaSetup[`UDC_DMA_DIR_BIT] || !outBufferEmpty);
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= n;
  end

  assign bus.rdata = q.rdata;
  assign bus.rdValid = q.rdValid;
  assign bus.dmaReq = q.dmaReq;
  assign fifoWrStrobe = q.fifoWr;
  assign fifoWrData = q.fifoWrData;
  assign fifoWrOneByte = q.fifoWrOneByte;
  assign fifoRdStrobe = q.fifoRd;
  assign fifoEp = q.fifoEp;
  assign bufferClear = q.bufClear;
  assign bufferValidate = q.bufValidate;
  assign dmaDone = q.dmaDone;
  assign cmdStrobe = q.cmdStrobe;
  assign cmdCode = q.cmd;
  assign devAddress = q.devAddr;
endmodule // udc_dev_end

// file: udc_port_props.sv
`timescale 1ns/1ps
module udc_port_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic acc,
  input wire logic wr,
  input wire logic phaseSelectAddrBit,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic rdValid,
  input wire logic dmaReq,
  input wire logic dmaAck,
  input wire logic transferStopInput
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // command phase carries a write with a clean upper byte
  property p_cmd_byte;
    acc && phaseSelectAddrBit |-> wr && wdata[15:8] == 8'h00;
  endproperty
  a_cmd_byte: assert property (p_cmd_byte)
    else $error("command phase with upper byte set");
  // every read access is answered one edge later
  property p_rd_answer;
    acc && !wr |=> rdValid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read access not answered");
  // read data only follows a read access or a dma read word
  property p_rd_cause;
    rdValid |-> ($past(acc) && !$past(wr)) || ($past(dmaAck) && $past(dmaReq) && !$past(wr));
  endproperty
  a_rd_cause: assert property (p_rd_cause)
    else $error("read data without a cause");
  // read data holds between answers
  property p_rdata_hold;
    !rdValid |-> $stable(rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without answer");
  // every access is a single one-cycle pulse
  property p_acc_gap;
    acc |=> !acc;
  endproperty
  a_acc_gap: assert property (p_acc_gap)
    else $error("access pulses too close");
  // stop input is a single pulse
  property p_stop_pulse;
    transferStopInput |=> !transferStopInput;
  endproperty
  a_stop_pulse: assert property (p_stop_pulse)
    else $error("stop input held");
  // stop input ends the request
  property p_stop_halts;
    transferStopInput |-> ##[1:3] !dmaReq;
  endproperty
  a_stop_halts: assert property (p_stop_halts)
    else $error("request stays after stop");
  // one dma word per acknowledge pulse
  property p_ack_pulse;
    dmaAck |=> !dmaAck;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("acknowledge held");
endmodule // udc_port_props

// file: usb_device_cmd_port_dma_eot_tb_top.sv
`timescale 1ns/1ps
`include "udc_cfg.svh"
module usb_device_cmd_port_dma_eot_tb_top;
  import udc_pkg::*;
  localparam int CE = 1 << `UDC_DMA_CNT_EN_BIT;
  localparam int RN = 1 << `UDC_DMA_RUN_BIT;
  localparam int SH = 1 << `UDC_DMA_SHORT_BIT;
  localparam int DI = 1 << `UDC_DMA_DIR_BIT;
  logic clk, rst, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] fifoRdData, fifoWrData, devAddress;
  logic outBufferEmpty, shortPacketRcvd, eopDetected, isoEndpoint;
  logic fifoWrStrobe, fifoWrOneByte, fifoRdStrobe, bufferClear, bufferValidate;
  logic dmaDone, cmdStrobe;
  logic [3:0] fifoEp;
  logic [7:0] cmdCode;
  int num_errors, cmp_count, seed, cyc;
  int obs[6];
  int exp[6];
  logic [15:0] mdl [int];
  int wc[8] = '{8'h20, 8'h21, 8'h2A, 8'h2F, 8'hB6, 8'hB8, 8'hBA, 8'hF2};
  udc_port_if portBus ();
  udc_host_end u_udc_host_end (.clk(clk), .rst(rst), .bus(portBus), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  udc_dev_end u_udc_dev_end (.clk(clk), .rst(rst), .bus(portBus), .fifoRdData(fifoRdData),
    .outBufferEmpty(outBufferEmpty), .shortPacketRcvd(shortPacketRcvd),
    .eopDetected(eopDetected), .isoEndpoint(isoEndpoint), .fifoWrStrobe(fifoWrStrobe),
    .fifoWrData(fifoWrData), .fifoWrOneByte(fifoWrOneByte), .fifoRdStrobe(fifoRdStrobe),
    .fifoEp(fifoEp), .bufferClear(bufferClear), .bufferValidate(bufferValidate),
    .dmaDone(dmaDone), .cmdStrobe(cmdStrobe), .cmdCode(cmdCode), .devAddress(devAddress));
  udc_port_props u_udc_port_props (.clk(clk), .rst(rst), .acc(portBus.acc),
    .wr(portBus.wr), .phaseSelectAddrBit(portBus.phaseSelectAddrBit),
    .wdata(portBus.wdata), .rdata(portBus.rdata), .rdValid(portBus.rdValid),
    .dmaReq(portBus.dmaReq), .dmaAck(portBus.dmaAck),
    .transferStopInput(portBus.transferStopInput));
  // clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic print_verdict();
    if (num_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    cmp_count++;
    if (got !== want)
    begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, want);
    end
  endtask
  // one single-word transfer; hready is sampled at rising edges, only the run limit ends a wait
  task automatic ahb(input logic w, input logic [4:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {27'h0, a};
    hwrite <= w;
    hsize <= 3'b010;
    @(posedge clk);
    while (hreadyout !== 1'b1)
      @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1)
      @(posedge clk);
    rd = hrdata;
  endtask
  task automatic cmd(input logic [7:0] c);
    ahb(1'b1, 5'h00, (32'($random(seed)) & 32'h0000FF00) | {24'h0, c});
    exp[5]++;
  endtask
  task automatic wdat(input logic [15:0] v);
    ahb(1'b1, 5'h04, {16'h0, v});
  endtask
  task automatic rdat(input logic [15:0] want);
    ahb(1'b0, 5'h04, 32'h0);
    chk(rd[15:0], want);
  endtask
  task automatic stat(input logic want);
    ahb(1'b0, 5'h0C, 32'h0);
    chk(rd[0], want);
    chk(hresp, 1'b0);
  endtask
  task automatic evts();
    repeat (3) @(posedge clk);
    for (int i = 0; i < 6; i++)
      chk(obs[i], exp[i]);
  endtask
  // kind: 0 count or short, 1 stop input, 2 run clear, 3 out short, 4 iso end
  task automatic dma(input int cfg, input int cnt, input int nw, input int kind);
    int d;
    d = 0;
    outBufferEmpty <= 1'b0;
    isoEndpoint <= (kind == 4);
    cmd(8'hF2);
    wdat(cnt[15:0]);
    cmd(8'hF0);
    wdat(cfg[15:0]);
    stat(1'b1);
    if (kind == 3)
    begin
      shortPacketRcvd <= 1'b1;
      @(posedge clk);
      shortPacketRcvd <= 1'b0;
    end
    for (int i = 0; i < nw; i++)
    begin
      if (cfg & DI)
      begin
        d = $random(seed);
        ahb(1'b1, 5'h08, d);
        exp[0]++;
      end
      else
      begin
        fifoRdData <= $random(seed);
        ahb(1'b0, 5'h08, 32'h0);
        chk(rd[15:0], fifoRdData);
        exp[1]++;
      end
      if (i < nw - 1)
        stat(1'b1);
    end
    case (kind)
      0: exp[3] += (cfg & DI) ? 1 : 0;
      1: begin ahb(1'b1, 5'h10, 32'h1); exp[(cfg & DI) ? 3 : 2]++; end
      2: begin cmd(8'hF0); wdat(16'(cfg & ~RN)); end
      3: outBufferEmpty <= 1'b1;
      4: begin eopDetected <= 1'b1; @(posedge clk); eopDetected <= 1'b0; end
      default: ;
    endcase
    if (kind != 2)
      exp[4]++;
    evts();
    chk(fifoEp, 4'(cfg >> 8));
    if (cfg & DI)
      chk(fifoWrData, d[15:0]);
    if (cfg & CE)
      chk(fifoWrOneByte, cnt[0]);
    stat(1'b0);
  endtask
  // event counts and run limit
  always @(posedge clk)
  begin
    cyc++;
    obs[0] += (fifoWrStrobe === 1'b1);
    obs[1] += (fifoRdStrobe === 1'b1);
    obs[2] += (bufferClear === 1'b1);
    obs[3] += (bufferValidate === 1'b1);
    obs[4] += (dmaDone === 1'b1);
    obs[5] += (cmdStrobe === 1'b1);
    if (cyc > 30000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  // main sequence
  initial
  begin
    seed = 67891;
    {hsel, hwrite, haddr, hwdata, htrans, hsize, fifoRdData} = '0;
    {outBufferEmpty, shortPacketRcvd, eopDetected, isoEndpoint} = 4'b1000;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      mdl[wc[i]] = $random(seed);
      cmd(wc[i]);
      wdat(mdl[wc[i]]);
    end
    for (int i = 0; i < 8; i++)
    begin
      cmd(wc[i] < 8'h30 ? wc[i] + 8'h10 : wc[i] + 1);
      rdat(mdl[wc[i]]);
    end
    chk(devAddress, mdl[8'hB6]);
    mdl[0] = $random(seed);
    mdl[1] = $random(seed);
    cmd(8'hC2);
    wdat(mdl[0]);
    wdat(mdl[1]);
    cmd(8'hC3);
    rdat(mdl[0]);
    rdat(mdl[1]);
    cmd(8'h02);
    wdat(16'h0003);
    wdat(mdl[0]);
    wdat(mdl[1]);
    exp[0] += 3;
    fifoRdData <= mdl[0];
    cmd(8'h12);
    rdat(mdl[0]);
    exp[1]++;
    cmd(8'h65);
    exp[3]++;
    cmd(8'h74);
    exp[2]++;
    evts();
    chk(fifoWrOneByte, 1'b1);
    chk(fifoWrData, mdl[1]);
    chk(fifoEp, 4'h4);
    chk(cmdCode, 8'h74);
    cmd(8'hF6);
    cmd(8'hB7);
    rdat(16'h0000);
    chk(devAddress, 16'h0000);
    dma(RN | CE | DI | 16'h0300, 5, 3, 0);
    dma(RN | SH | DI, 4, 2, 0);
    dma(RN | DI, 9, 1, 1);
    dma(RN, 9, 1, 1);
    dma(RN | DI, 9, 1, 2);
    dma(RN | SH, 9, 1, 3);
    dma(RN, 9, 1, 4);
    print_verdict();
  end
endmodule // usb_device_cmd_port_dma_eot_tb_top
